// ==== src/acfg_ctrl.sv ====
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Deep stop entry disables the converter automatically
// - Registers hold reset values after deep stop
// - Configuration bit 7 selects low power
// - Bits 6:5 divide input clock; 00 is one
// - Bit 4 selects long sample period
// - Bits 3:2 choose resolution; 10 is ten-bit
// - Bits 1:0 select clock source; 00 bus
// - Control two bit 7 shows conversion active
// - Control two bit 6 selects hardware trigger
// - Bit 5 enables compare; bit 4 direction
// - Direction one: greater-or-equal; zero: below
// - Control two bits 3:2 read zero
// - Control one bit 7 is complete flag
// - Control one bit 6 enables complete interrupt
// - Control one bit 5 selects continuous conversions
// - Control one bits 4:0 select channel
// - Result presented in two-byte register pair
// - High-byte read locks result until low read
// - Two-byte compare value register holds reference
// - Pin-control bits disable digital pin I/O
module acfg_ctrl (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RST_N,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic             PREADY,
	output logic [31:0]      PRDATA,
	output logic             PSLVERR,
	// System and analog side
	input  wire logic        DEEP_STOP,
	input  wire logic        HW_TRIGGER,
	input  wire logic        ALT_CLK_TICK,
	input  wire logic        ASYNC_CLK_TICK,
	input  wire logic [11:0] ANALOG_CODE,
	output logic [4:0]       CHANNEL_SELECT,
	output logic             LOW_POWER_SELECT,
	output logic             SAMPLE_ENABLE,
	output logic             CONVERSION_ACTIVE,
	output logic             COMPLETE_IRQ,
	output logic [15:0]      PIN_DISABLE
);
	// Whole module state
	typedef struct packed {
		logic [7:0]  cfg;        // Configuration register
		logic [7:0]  sc2;        // Control two, writable bits
		logic [7:0]  sc1;        // Control one, writable bits
		logic        conversion_complete_flag;       // Complete flag
		logic        active;     // Conversion in progress
		logic [11:0] result;     // Result pair
		logic [11:0] lock_res;   // Frozen result for low-byte read
		logic        locked;     // High byte read, awaiting low
		logic [11:0] cmp_val;    // Compare value
		logic [15:0] pins;       // Pin control pair
		acfg_pkg::acfg_state_t st; // Sequencer state
		logic [5:0]  cnt;        // Phase counter in conversion clocks
		logic [2:0]  divc;       // Divider counter
		logic        tick_q;     // Divided conversion clock pulse
		logic        hw_q;       // Previous hardware trigger level
		logic        pready;     // APB ready
		logic [31:0] prdata;     // APB read data
		logic        pslverr;    // APB error
	} acfg_state_s_t;

	acfg_state_s_t s_q;          // Registered state
	acfg_state_s_t s_d;          // Next state
	logic          src_tick;     // Selected input clock pulse
	logic          div_hit;      // Divider terminal count
	logic [2:0]    div_max;      // Divider limit
	logic          acc;          // APB access phase
	logic          wr;           // Write in access phase
	logic          rd;           // Read in access phase
	logic          start;        // Conversion start request
	logic [11:0]   code;         // Resolution-trimmed code
	logic [11:0]   diff;         // Result minus compare value
	logic          cmp_ok;       // Compare condition met
	logic [11:0]   shown;        // Result seen by reads

	// Input clock source and divider
	always_comb begin
		case (s_q.cfg[acfg_pkg::ICLK_LSB +: 2])
			2'h0:    src_tick = 1'b1;
			2'h1:    src_tick = s_q.divc[0];
			2'h2:    src_tick = ALT_CLK_TICK;
			default: src_tick = ASYNC_CLK_TICK;
		endcase
		div_max = 3'((4'h1 << s_q.cfg[acfg_pkg::DIV_LSB +: 2]) - 4'h1);
		div_hit = src_tick && (s_q.divc[1:0] >= div_max[1:0] || div_max == 3'h7);
	end

	// Result trimmed to the chosen resolution
	always_comb begin
		case (s_q.cfg[acfg_pkg::MODE_LSB +: 2])
			2'h0:    code = {4'h0, ANALOG_CODE[11:4]};
			2'h2:    code = {2'h0, ANALOG_CODE[11:2]};
			default: code = ANALOG_CODE;
		endcase
		diff = code - s_q.cmp_val;
		// Direction one tests at or above, zero tests below
		cmp_ok = s_q.sc2[acfg_pkg::CGT_BIT] ? (code >= s_q.cmp_val)
			: (code < s_q.cmp_val);
		shown = s_q.locked ? s_q.lock_res : s_q.result;
	end

	// Bus decode
	assign acc = PSEL && PENABLE && !s_q.pready;
	assign wr  = acc && PWRITE;
	assign rd  = acc && !PWRITE;

	// Next state
	always_comb begin
		s_d = s_q;
		s_d.pready = acc;
		s_d.pslverr = 1'b0;
		s_d.prdata = 32'h0000_0000;
		s_d.hw_q = HW_TRIGGER;
		s_d.divc = src_tick ? s_q.divc + 3'h1 : s_q.divc;
		s_d.tick_q = div_hit;
		if (div_hit) begin
			s_d.divc = 3'h0;
		end
		start = 1'b0;
		// Register reads
		if (rd) begin
			case (PADDR)
				acfg_pkg::CFG_OFS:  s_d.prdata = {24'h0, s_q.cfg};
				acfg_pkg::SC2_OFS:  s_d.prdata = {24'h0, s_q.active, s_q.sc2[6:4],
					4'h0};
				acfg_pkg::SC1_OFS:  s_d.prdata = {24'h0, s_q.conversion_complete_flag, s_q.sc1[6:0]};
				acfg_pkg::RESH_OFS: begin
					s_d.prdata = {28'h0, shown[11:8]};
					s_d.locked = 1'b1;
					s_d.lock_res = shown;
				end
				acfg_pkg::RESL_OFS: begin
					s_d.prdata = {24'h0, shown[7:0]};
					s_d.locked = 1'b0;
					s_d.conversion_complete_flag = 1'b0;
				end
				acfg_pkg::CVH_OFS:  s_d.prdata = {28'h0, s_q.cmp_val[11:8]};
				acfg_pkg::CVL_OFS:  s_d.prdata = {24'h0, s_q.cmp_val[7:0]};
				acfg_pkg::PIN1_OFS: s_d.prdata = {24'h0, s_q.pins[7:0]};
				acfg_pkg::PIN2_OFS: s_d.prdata = {24'h0, s_q.pins[15:8]};
				default:            s_d.pslverr = 1'b1;
			endcase
		end
		// Register writes
		if (wr) begin
			case (PADDR)
				acfg_pkg::CFG_OFS: s_d.cfg = PWDATA[7:0];
				acfg_pkg::SC2_OFS: s_d.sc2 = PWDATA[7:0] & acfg_pkg::SC2_WMASK;
				acfg_pkg::SC1_OFS: begin
					s_d.sc1 = {1'b0, PWDATA[6:0]};
					s_d.conversion_complete_flag = 1'b0;
					s_d.active = 1'b0;
					s_d.st = acfg_pkg::ACFG_IDLE;
					start = !s_q.sc2[acfg_pkg::TRG_BIT] && PWDATA[4:0] != 5'h1F;
				end
				acfg_pkg::CVH_OFS:  s_d.cmp_val[11:8] = PWDATA[3:0];
				acfg_pkg::CVL_OFS:  s_d.cmp_val[7:0] = PWDATA[7:0];
				acfg_pkg::PIN1_OFS: s_d.pins[7:0] = PWDATA[7:0];
				acfg_pkg::PIN2_OFS: s_d.pins[15:8] = PWDATA[7:0];
				default:            s_d.pslverr = 1'b1;
			endcase
		end
		// Hardware trigger on rising edge
		if (s_q.sc2[acfg_pkg::TRG_BIT] && HW_TRIGGER && !s_q.hw_q
			&& s_q.st == acfg_pkg::ACFG_IDLE && s_q.sc1[4:0] != 5'h1F) begin
			start = 1'b1;
		end
		// Conversion sequencer
		case (s_q.st)
			acfg_pkg::ACFG_IDLE: begin
				// Waits for a start request below
			end
			acfg_pkg::ACFG_SAMPLE: begin
				if (s_q.tick_q) begin
					s_d.cnt = s_q.cnt - 6'h1;
					if (s_q.cnt == 6'h1) begin
						s_d.st = acfg_pkg::ACFG_CONVERT;
						s_d.cnt = acfg_pkg::SAR_CYC;
					end
				end
			end
			acfg_pkg::ACFG_CONVERT: begin
				if (s_q.tick_q) begin
					s_d.cnt = s_q.cnt - 6'h1;
					if (s_q.cnt == 6'h1) begin
						// Compare failure leaves result and flag untouched
						if (!s_q.sc2[acfg_pkg::CFE_BIT] || cmp_ok) begin
							s_d.result = s_q.sc2[acfg_pkg::CFE_BIT] ? diff : code;
							s_d.conversion_complete_flag = 1'b1;
						end
						if (s_q.sc1[acfg_pkg::CONT_BIT]) begin
							s_d.st = acfg_pkg::ACFG_SAMPLE;
							s_d.cnt = s_q.cfg[acfg_pkg::LSMP_BIT] ? acfg_pkg::LONG_SMP_CYC
								: acfg_pkg::SHORT_SMP_CYC;
						end else begin
							s_d.st = acfg_pkg::ACFG_IDLE;
							s_d.active = 1'b0;
						end
					end
				end
			end
			default: s_d.st = acfg_pkg::ACFG_IDLE;
		endcase
		// Start from any state, so a control one write mid-conversion restarts it unless hardware trigger or channel 1F is selected
		if (start) begin
			s_d.st = acfg_pkg::ACFG_SAMPLE;
			s_d.active = 1'b1;
			s_d.cnt = s_q.cfg[acfg_pkg::LSMP_BIT] ? acfg_pkg::LONG_SMP_CYC
				: acfg_pkg::SHORT_SMP_CYC;
		end
		// Deep stop forces every register except APB ready back to reset
		if (DEEP_STOP) begin
			s_d = '0;
			s_d.cfg = acfg_pkg::CFG_RST;
			s_d.sc2 = acfg_pkg::SC2_RST;
			s_d.sc1 = acfg_pkg::SC1_RST;
			s_d.st = acfg_pkg::ACFG_IDLE;
			s_d.pready = acc;
		end
	end

	// State register
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_q <= '{cfg: acfg_pkg::CFG_RST, sc2: acfg_pkg::SC2_RST,
				sc1: acfg_pkg::SC1_RST, st: acfg_pkg::ACFG_IDLE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from state
	assign PREADY            = s_q.pready;
	assign PRDATA            = s_q.prdata;
	assign PSLVERR           = s_q.pslverr;
	assign CHANNEL_SELECT    = s_q.sc1[4:0];
	assign LOW_POWER_SELECT  = s_q.cfg[acfg_pkg::LP_BIT];
	assign SAMPLE_ENABLE     = (s_q.st == acfg_pkg::ACFG_SAMPLE);
	assign CONVERSION_ACTIVE = s_q.active;
	assign COMPLETE_IRQ      = s_q.conversion_complete_flag && s_q.sc1[acfg_pkg::COMPLETE_INTERRUPT_ENABLE_BIT];
	assign PIN_DISABLE       = s_q.pins;

	// Checks
	stop_clears_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		DEEP_STOP |=> !s_q.active && s_q.cfg == acfg_pkg::CFG_RST)
		else $error("deep stop did not reset");
	stop_regs_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		DEEP_STOP |=> s_q.pins == 16'h0 && s_q.sc1 == acfg_pkg::SC1_RST)
		else $error("registers not at reset after deep stop");
	sw_start_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(wr && PADDR == acfg_pkg::SC1_OFS && !s_q.sc2[acfg_pkg::TRG_BIT]
		&& PWDATA[4:0] != 5'h1F && !DEEP_STOP) |=> s_q.active)
		else $error("software start missing");
	sc2_res_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		$rose(PREADY) && $past(PADDR) == acfg_pkg::SC2_OFS && !$past(PWRITE)
		|-> PRDATA[3:0] == 4'h0)
		else $error("reserved bits read nonzero");
	lock_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_q.locked && !DEEP_STOP && !rd |=> $stable(s_q.lock_res))
		else $error("locked result changed");
	irq_gate_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		!s_q.sc1[acfg_pkg::COMPLETE_INTERRUPT_ENABLE_BIT] |-> !COMPLETE_IRQ)
		else $error("interrupt without enable");
	single_end_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		$fell(s_q.active) && !$past(DEEP_STOP) && !$past(wr)
		|-> !s_q.sc1[acfg_pkg::CONT_BIT])
		else $error("continuous mode stopped");
	cmp_gate_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_q.st == acfg_pkg::ACFG_CONVERT && s_q.tick_q && s_q.cnt == 6'h1
		&& s_q.sc2[acfg_pkg::CFE_BIT] && !cmp_ok && !s_q.conversion_complete_flag && !wr && !DEEP_STOP
		|=> !s_q.conversion_complete_flag)
		else $error("compare failure set flag");

	// Configuration word lands as written
	cfg_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		wr && PADDR == acfg_pkg::CFG_OFS && !DEEP_STOP |=> s_q.cfg == $past(PWDATA[7:0]))
		else $error("configuration write lost");
	// Control two keeps only trigger and compare bits
	sc2_mask_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		wr && PADDR == acfg_pkg::SC2_OFS && !DEEP_STOP
		|=> s_q.sc2 == ($past(PWDATA[7:0]) & acfg_pkg::SC2_WMASK))
		else $error("control two write wrong");

	// Pin control bytes land as written
	pin_low_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		wr && PADDR == acfg_pkg::PIN1_OFS && !DEEP_STOP |=> PIN_DISABLE[7:0] == $past(PWDATA[7:0]))
		else $error("first pin byte wrong");
	// Upper pin byte
	pin_high_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		wr && PADDR == acfg_pkg::PIN2_OFS && !DEEP_STOP |=> PIN_DISABLE[15:8] == $past(PWDATA[7:0]))
		else $error("second pin byte wrong");

	// Compare value halves land as written
	cv_low_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		wr && PADDR == acfg_pkg::CVL_OFS && !DEEP_STOP |=> s_q.cmp_val[7:0] == $past(PWDATA[7:0]))
		else $error("compare low byte wrong");
	// Upper compare bits
	cv_high_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		wr && PADDR == acfg_pkg::CVH_OFS && !DEEP_STOP |=> s_q.cmp_val[11:8] == $past(PWDATA[3:0]))
		else $error("compare high bits wrong");

	// Active flag mirrors a busy sequencer
	active_flag_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_q.active == (s_q.st != acfg_pkg::ACFG_IDLE))
		else $error("active flag out of step");
	// Bus clock divided by one ticks every cycle
	div_one_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_q.cfg[acfg_pkg::DIV_LSB +: 2] == 2'h0 && s_q.cfg[acfg_pkg::ICLK_LSB +: 2] == 2'h0
		|-> div_hit)
		else $error("divide by one missed a tick");

	// Hardware edge starts a conversion
	hw_start_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_q.sc2[acfg_pkg::TRG_BIT] && HW_TRIGGER && !s_q.hw_q && s_q.st == acfg_pkg::ACFG_IDLE
		&& s_q.sc1[4:0] != 5'h1F && !wr && !DEEP_STOP |=> s_q.active)
		else $error("hardware start missing");
	// Hardware trigger ignores control one writes
	sw_block_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		wr && PADDR == acfg_pkg::SC1_OFS && s_q.sc2[acfg_pkg::TRG_BIT]
		&& !(HW_TRIGGER && !s_q.hw_q) |=> !s_q.active)
		else $error("software start in hardware mode");

	// Finished conversion raises the complete flag
	conversion_complete_flag_set_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_q.st == acfg_pkg::ACFG_CONVERT && s_q.tick_q && s_q.cnt == 6'h1
		&& (!s_q.sc2[acfg_pkg::CFE_BIT] || cmp_ok) && !DEEP_STOP |=> s_q.conversion_complete_flag)
		else $error("complete flag not set");
	// Long sample loads the long count
	long_sample_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		start && s_q.cfg[acfg_pkg::LSMP_BIT] && !DEEP_STOP |=> s_q.cnt == acfg_pkg::LONG_SMP_CYC)
		else $error("long sample count wrong");
	// Short sample loads the short count
	short_sample_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		start && !s_q.cfg[acfg_pkg::LSMP_BIT] && !DEEP_STOP
		|=> s_q.cnt == acfg_pkg::SHORT_SMP_CYC)
		else $error("short sample count wrong");

	// Ten-bit mode keeps the top bits clear
	res_mode_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_q.cfg[acfg_pkg::MODE_LSB +: 2] == 2'h2 |-> code[11:10] == 2'h0)
		else $error("ten-bit code too wide");
	// Deep stop leaves the sequencer idle
	stop_idle_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		DEEP_STOP |=> s_q.st == acfg_pkg::ACFG_IDLE && !SAMPLE_ENABLE)
		else $error("sequencer busy after deep stop");
	// High byte read carries only four bits
	res_high_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		rd && PADDR == acfg_pkg::RESH_OFS |=> PRDATA[31:4] == 28'h0)
		else $error("high byte read too wide");
	// High byte read sets the lock
	lock_set_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		rd && PADDR == acfg_pkg::RESH_OFS && !DEEP_STOP |=> s_q.locked)
		else $error("high byte read did not lock");

	// Main scenarios reached
	single_cv: cover property (@(posedge REF_CLK) disable iff (!RST_N) $rose(s_q.conversion_complete_flag));
	lock_cv: cover property (@(posedge REF_CLK) disable iff (!RST_N) s_q.locked && s_q.active);
	hw_cv: cover property (@(posedge REF_CLK) disable iff (!RST_N)
		s_q.sc2[acfg_pkg::TRG_BIT] && $rose(s_q.active));
	cont_cv: cover property (@(posedge REF_CLK) disable iff (!RST_N)
		s_q.conversion_complete_flag && s_q.sc1[acfg_pkg::CONT_BIT] && s_q.active);
	stop_cv: cover property (@(posedge REF_CLK) disable iff (!RST_N)
		DEEP_STOP && s_q.active);
endmodule

// ==== src/acfg_pkg.sv ====
package acfg_pkg;
	// Register byte addresses, one aligned word each
	localparam logic [7:0] CFG_OFS     = 8'h00;
	localparam logic [7:0] SC2_OFS     = 8'h04;
	localparam logic [7:0] SC1_OFS     = 8'h08;
	localparam logic [7:0] RESH_OFS    = 8'h0C;
	localparam logic [7:0] RESL_OFS    = 8'h10;
	localparam logic [7:0] CVH_OFS     = 8'h14;
	localparam logic [7:0] CVL_OFS     = 8'h18;
	localparam logic [7:0] PIN1_OFS    = 8'h1C;
	localparam logic [7:0] PIN2_OFS    = 8'h20;
	// Field positions
	localparam int LP_BIT   = 7;
	localparam int DIV_LSB  = 5;
	localparam int LSMP_BIT = 4;
	localparam int MODE_LSB = 2;
	localparam int ICLK_LSB = 0;
	localparam int ACT_BIT  = 7;
	localparam int TRG_BIT  = 6;
	localparam int CFE_BIT  = 5;
	localparam int CGT_BIT  = 4;
	localparam int CONVERSION_COMPLETE_FLAG_BIT = 7;
	localparam int COMPLETE_INTERRUPT_ENABLE_BIT = 6;
	localparam int CONT_BIT = 5;
	// Reset values
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] SC2_RST = 8'h00;
	localparam logic [7:0] SC1_RST = 8'h1F;
	localparam logic [7:0] SC2_WMASK = 8'h70;
	// Conversion clock cycles per conversion phase
	localparam logic [5:0] SHORT_SMP_CYC = 6'h04;
	localparam logic [5:0] LONG_SMP_CYC  = 6'h18;
	localparam logic [5:0] SAR_CYC       = 6'h14;
	// Conversion sequencer states
	typedef enum logic [1:0] {ACFG_IDLE, ACFG_SAMPLE, ACFG_CONVERT} acfg_state_t;
endpackage

// ==== testbench/acfg_ctrl_test.sv ====
`timescale 1ns/1ps
module acfg_ctrl_test;
	// Bus and system inputs
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        deep_stop = 1'b0;
	logic        hw_trig = 1'b0;
	logic [11:0] code = 12'hAAA;
	// Design outputs
	logic        pready, pslverr, lp_sel, conv_act, irq, samp;
	logic [31:0] prdata;
	logic [4:0]  chan;
	logic [15:0] pin_dis;
	// Bookkeeping
	int          err_total = 0;
	int          n_checks = 0;
	int          i;
	logic [31:0] rs = 32'h0000_8E6A;
	logic [31:0] rd;
	logic        re;
	// Short register addresses
	localparam logic [7:0] a_cfg = acfg_pkg::CFG_OFS;
	localparam logic [7:0] a_sc2 = acfg_pkg::SC2_OFS;
	localparam logic [7:0] a_sc1 = acfg_pkg::SC1_OFS;

	// Bus clock, 20 ns period
	always #10 clk = ~clk;

	acfg_ctrl i_acfg_ctrl (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
		.PRDATA(prdata), .PSLVERR(pslverr), .DEEP_STOP(deep_stop),
		.HW_TRIGGER(hw_trig), .ALT_CLK_TICK(1'b0), .ASYNC_CLK_TICK(1'b0),
		.ANALOG_CODE(code), .CHANNEL_SELECT(chan), .LOW_POWER_SELECT(lp_sel),
		.SAMPLE_ENABLE(samp), .CONVERSION_ACTIVE(conv_act), .COMPLETE_IRQ(irq),
		.PIN_DISABLE(pin_dis));

	// Next pseudo-random word
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Counts, verdict and end of run
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Value comparison
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One bus transfer, held until ready is sampled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			err_total++;
			final_report();
		end
	endtask

	// Read and compare
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	// Poll the complete flag, bounded
	task automatic wcoco();
		int n;
		for (n = 0; n < 200; n++) begin
			apb(1'b0, a_sc1, 32'h0);
			if (rd[acfg_pkg::CONVERSION_COMPLETE_FLAG_BIT] === 1'b1) break;
		end
		chk("complete flag", 32'h1, {31'h0, rd[7]});
		if (n == 200) final_report();
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rchk("cfg reset", a_cfg, {24'h0, acfg_pkg::CFG_RST});
		rchk("sc2 reset", a_sc2, {24'h0, acfg_pkg::SC2_RST});
		rchk("sc1 reset", a_sc1, {24'h0, acfg_pkg::SC1_RST});
		$display("test reset done");
		// Random configuration words read back
		for (i = 0; i < 8; i++) begin
			rs = lfsr(rs);
			apb(1'b1, a_cfg, {24'h0, rs[7:0]});
			rchk("cfg rw", a_cfg, {24'h0, rs[7:0]});
			chk("low power", {31'h0, rs[7]}, {31'h0, lp_sel});
		end
		// Reserved control bits read zero
		apb(1'b1, a_sc2, 32'h7C);
		rchk("sc2 mask", a_sc2, 32'h70);
		apb(1'b1, a_sc2, 32'h0);
		// Pin control, random then single pin
		rs = lfsr(rs);
		apb(1'b1, acfg_pkg::PIN1_OFS, {24'h0, rs[7:0]});
		apb(1'b1, acfg_pkg::PIN2_OFS, {24'h0, rs[15:8]});
		chk("pin random", {16'h0, rs[15:0]}, {16'h0, pin_dis});
		apb(1'b1, acfg_pkg::PIN1_OFS, 32'h02);
		apb(1'b1, acfg_pkg::PIN2_OFS, 32'h00);
		chk("pin one", 32'h2, {16'h0, pin_dis});
		$display("test registers done");
		// Single ten-bit conversion on channel one
		apb(1'b1, a_cfg, 32'h98);
		apb(1'b1, a_sc2, 32'h00);
		apb(1'b1, a_sc1, 32'h41);
		chk("channel", 32'h1, {27'h0, chan});
		chk("sampling", 32'h1, {31'h0, samp});
		rchk("active", a_sc2, 32'h80);
		wcoco();
		chk("irq set", 32'h1, {31'h0, irq});
		rchk("res high", acfg_pkg::RESH_OFS, 32'h02);
		rchk("res low", acfg_pkg::RESL_OFS, 32'hAA);
		rchk("sc1 single", a_sc1, 32'h41);
		chk("irq clear", 32'h0, {31'h0, irq});
		$display("test single done");
		// Continuous mode with high byte lock
		code <= 12'h555;
		apb(1'b1, a_sc1, 32'h21);
		wcoco();
		rchk("lock high", acfg_pkg::RESH_OFS, 32'h01);
		code <= 12'hAAA;
		repeat (400) @(posedge clk);
		rchk("lock low", acfg_pkg::RESL_OFS, 32'h55);
		wcoco();
		rchk("next high", acfg_pkg::RESH_OFS, 32'h02);
		rchk("next low", acfg_pkg::RESL_OFS, 32'hAA);
		apb(1'b1, a_sc1, 32'h1F);
		$display("test continuous done");
		// Compare both directions against 0x101
		apb(1'b1, acfg_pkg::CVH_OFS, 32'h01);
		apb(1'b1, acfg_pkg::CVL_OFS, 32'h01);
		for (i = 0; i < 3; i++) begin
			code <= (i == 2) ? 12'h000 : 12'hAAA;
			apb(1'b1, a_sc2, (i == 0) ? 32'h30 : 32'h20);
			apb(1'b1, a_sc1, 32'h01);
			repeat (400) @(posedge clk);
			rchk("cmp flag", a_sc1, (i == 1) ? 32'h01 : 32'h81);
			if (i == 0) rchk("cmp diff", acfg_pkg::RESL_OFS, 32'hA9);
			apb(1'b1, a_sc1, 32'h1F);
		end
		$display("test compare done");
		// Hardware trigger ignores the control write
		apb(1'b1, a_sc2, 32'h40);
		apb(1'b1, a_sc1, 32'h01);
		repeat (300) @(posedge clk);
		rchk("no sw start", a_sc1, 32'h01);
		hw_trig <= 1'b1;
		wcoco();
		hw_trig <= 1'b0;
		$display("test trigger done");
		// Deep stop mid conversion
		apb(1'b1, a_sc2, 32'h00);
		apb(1'b1, a_sc1, 32'h01);
		deep_stop <= 1'b1;
		repeat (3) @(posedge clk);
		chk("stop idle", 32'h0, {31'h0, conv_act});
		deep_stop <= 1'b0;
		rchk("stop cfg", a_cfg, 32'h00);
		rchk("stop sc1", a_sc1, 32'h1F);
		chk("stop pins", 32'h0, {16'h0, pin_dis});
		// Reconfigure in order before converting again
		apb(1'b1, a_cfg, 32'h98);
		apb(1'b1, a_sc2, 32'h00);
		apb(1'b1, a_sc1, 32'h01);
		wcoco();
		$display("test deep stop done");
		// Unmapped address refused
		apb(1'b1, 8'h40, 32'hFF);
		chk("unmapped err", 32'h1, {31'h0, re});
		rchk("cfg kept", a_cfg, 32'h98);
		$display("test unmapped done");
		final_report();
	end

	// Overall run limit
	initial begin
		#1500000;
		err_total++;
		final_report();
	end
endmodule
